// >>> common/mpc_pkg.sv
// Purpose: constants and carriers for the motor port pin control block
// Assumes: apb slave with 32-bit data, one word per register
// Notes: offsets chosen for this block; unmapped reads return zero

package mpc_pkg;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] MPC_OFF_U_LATCH = 12'h000;
   localparam logic [11:0] MPC_OFF_U_PINS = 12'h004;
   localparam logic [11:0] MPC_OFF_U_DIR = 12'h008;
   localparam logic [11:0] MPC_OFF_U_SLEW = 12'h00c;
   localparam logic [11:0] MPC_OFF_U_PULLEN = 12'h010;
   localparam logic [11:0] MPC_OFF_U_PULLPOL = 12'h014;
   localparam logic [11:0] MPC_OFF_V_LATCH = 12'h020;
   localparam logic [11:0] MPC_OFF_V_PINS = 12'h024;
   localparam logic [11:0] MPC_OFF_V_DIR = 12'h028;
   localparam logic [11:0] MPC_OFF_V_SLEW = 12'h02c;
   localparam logic [11:0] MPC_OFF_V_PULLEN = 12'h030;
   localparam logic [11:0] MPC_OFF_V_PULLPOL = 12'h034;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] MPC_RST_LATCH = 8'h00;
   localparam logic [7:0] MPC_RST_DIR = 8'h00;
   localparam logic [7:0] MPC_RST_SLEW = 8'h00;
   localparam logic [7:0] MPC_RST_PULLEN = 8'h00;
   localparam logic [7:0] MPC_RST_PULLPOL = 8'h00;

   // number of synchroniser stages on pin inputs
   localparam int MPC_SYNC_STAGES = 2;

   // per-port software configuration
   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] dir;
      logic [7:0] slew;
      logic [7:0] pullen;
      logic [7:0] pullpol;
   } mpc_port_cfg_t;

   // per-port pad controls
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull_en;
      logic [7:0] pull_dn;
      logic [7:0] slew_en;
      logic [7:0] ibuf_en;
   } mpc_pad_t;

endpackage

// >>> hw/mpc_motor_port.sv
// Purpose: pin ownership, pad control and apb registers for motor ports u and v
// Assumes: stall detector and pwm outputs come from logic on clk
// Notes: pins are synchronised before any readback; apb answers after one wait state

`timescale 1ns/1ps
`default_nettype none

module mpc_motor_port
   import mpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // stall detector instances 0..3: enable, drive value, drive enable
   input wire logic [3:0] stall_detector_en,
   input wire logic [15:0] stall_detector_out,
   input wire logic [15:0] stall_detector_oe,
   // motor pwm channels 0..7, two pins each
   input wire logic [7:0] motor_pwm_controller_en,
   input wire logic [15:0] motor_pwm_controller_out,
   // pads, u in bits 7:0, v in bits 15:8
   input wire logic [15:0] pad_in,
   output logic [15:0] pad_out,
   output logic [15:0] pad_oe,
   output logic [15:0] pad_pull_en,
   output logic [15:0] pad_pull_dn,
   output logic [15:0] pad_slew_en,
   output logic [15:0] pad_ibuf_en
);

   // ---------------------------------------------------------------
   // configuration storage
   // ---------------------------------------------------------------
   // one byte per register; the carriers below only regroup these flops
   logic [7:0] u_latch_q;
   logic [7:0] u_dir_q;
   logic [7:0] u_slew_q;
   logic [7:0] u_pullen_q;
   logic [7:0] u_pullpol_q;
   logic [7:0] v_latch_q;
   logic [7:0] v_dir_q;
   logic [7:0] v_slew_q;
   logic [7:0] v_pullen_q;
   logic [7:0] v_pullpol_q;
   mpc_port_cfg_t cfg_u;
   mpc_port_cfg_t cfg_v;

   assign cfg_u = '{u_latch_q, u_dir_q, u_slew_q, u_pullen_q, u_pullpol_q};
   assign cfg_v = '{v_latch_q, v_dir_q, v_slew_q, v_pullen_q, v_pullpol_q};

   // ---------------------------------------------------------------
   // apb request decode
   // ---------------------------------------------------------------
   // a write lands only at the edge that completes the access, so a
   // master holding its request through the wait state writes once
   logic pready_q;
   logic wr_en;
   logic rd_en;
   logic wr_u_latch;
   logic wr_u_dir;
   logic wr_u_slew;
   logic wr_u_pullen;
   logic wr_u_pullpol;
   logic wr_v_latch;
   logic wr_v_dir;
   logic wr_v_slew;
   logic wr_v_pullen;
   logic wr_v_pullpol;

   assign wr_en = psel && penable && pwrite && pready_q;
   assign rd_en = psel && penable && !pwrite;
   // readback offsets have no strobe, so writes there vanish
   assign wr_u_latch = wr_en && (paddr == MPC_OFF_U_LATCH);
   assign wr_u_dir = wr_en && (paddr == MPC_OFF_U_DIR);
   assign wr_u_slew = wr_en && (paddr == MPC_OFF_U_SLEW);
   assign wr_u_pullen = wr_en && (paddr == MPC_OFF_U_PULLEN);
   assign wr_u_pullpol = wr_en && (paddr == MPC_OFF_U_PULLPOL);
   assign wr_v_latch = wr_en && (paddr == MPC_OFF_V_LATCH);
   assign wr_v_dir = wr_en && (paddr == MPC_OFF_V_DIR);
   assign wr_v_slew = wr_en && (paddr == MPC_OFF_V_SLEW);
   assign wr_v_pullen = wr_en && (paddr == MPC_OFF_V_PULLEN);
   assign wr_v_pullpol = wr_en && (paddr == MPC_OFF_V_PULLPOL);

   // ---------------------------------------------------------------
   // port u registers
   // ---------------------------------------------------------------
   // every register accepts a write at any time
   always_ff @(posedge clk) begin
      if (rst) begin
         u_latch_q <= MPC_RST_LATCH;
      end else if (wr_u_latch) begin
         u_latch_q <= pwdata[7:0];
      end
   end

   // all pins start as inputs
   always_ff @(posedge clk) begin
      if (rst) begin
         u_dir_q <= MPC_RST_DIR;
      end else if (wr_u_dir) begin
         u_dir_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         u_slew_q <= MPC_RST_SLEW;
      end else if (wr_u_slew) begin
         u_slew_q <= pwdata[7:0];
      end
   end

   // pull settings are kept even while they have no effect
   always_ff @(posedge clk) begin
      if (rst) begin
         u_pullen_q <= MPC_RST_PULLEN;
      end else if (wr_u_pullen) begin
         u_pullen_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         u_pullpol_q <= MPC_RST_PULLPOL;
      end else if (wr_u_pullpol) begin
         u_pullpol_q <= pwdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // port v registers
   // ---------------------------------------------------------------
   // same layout as port u, reset to inputs without pull
   always_ff @(posedge clk) begin
      if (rst) begin
         v_latch_q <= MPC_RST_LATCH;
      end else if (wr_v_latch) begin
         v_latch_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         v_dir_q <= MPC_RST_DIR;
      end else if (wr_v_dir) begin
         v_dir_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         v_slew_q <= MPC_RST_SLEW;
      end else if (wr_v_slew) begin
         v_slew_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         v_pullen_q <= MPC_RST_PULLEN;
      end else if (wr_v_pullen) begin
         v_pullen_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         v_pullpol_q <= MPC_RST_PULLPOL;
      end else if (wr_v_pullpol) begin
         v_pullpol_q <= pwdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   logic [15:0] pin_meta_q;
   logic [15:0] pin_sync_q;

   // readback therefore lags the pad by two clocks
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_meta_q <= 16'h0000;
         pin_sync_q <= 16'h0000;
      end else begin
         pin_meta_q <= pad_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // ownership mux, one entry per pin
   // ---------------------------------------------------------------
   logic [15:0] dir_all;
   logic [15:0] latch_all;
   logic [15:0] slew_all;
   logic [15:0] pullen_all;
   logic [15:0] pullpol_all;
   logic [15:0] own_out_d;
   logic [15:0] own_oe_d;
   logic [15:0] pull_en_d;
   logic [15:0] pull_dn_d;

   assign dir_all = {cfg_v.dir, cfg_u.dir};
   assign latch_all = {cfg_v.latch, cfg_u.latch};
   assign slew_all = {cfg_v.slew, cfg_u.slew};
   assign pullen_all = {cfg_v.pullen, cfg_u.pullen};
   assign pullpol_all = {cfg_v.pullpol, cfg_u.pullpol};

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_pin
         // pin group of four: u[3:0]=0, u[7:4]=1, v[3:0]=2, v[7:4]=3
         localparam int GRP = gi / 4;
         localparam int PWM = gi / 2;
         logic sd_own;
         logic pwm_own;
         assign sd_own = stall_detector_en[GRP];
         assign pwm_own = motor_pwm_controller_en[PWM];
         always_comb begin
            // fixed priority: detector, pwm, gpio
            if (sd_own) begin
               own_out_d[gi] = stall_detector_out[gi];
               own_oe_d[gi] = stall_detector_oe[gi];
            end else if (pwm_own) begin
               // pwm forces output, direction ignored
               own_out_d[gi] = motor_pwm_controller_out[gi];
               own_oe_d[gi] = 1'b1;
            end else begin
               // direction bit back in charge
               own_out_d[gi] = latch_all[gi];
               own_oe_d[gi] = dir_all[gi];
            end
            // pull only on a gpio input; polarity only then
            pull_en_d[gi] = !sd_own && !pwm_own && !dir_all[gi] && pullen_all[gi];
            pull_dn_d[gi] = pull_en_d[gi] && pullpol_all[gi];
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // pad registers
   // ---------------------------------------------------------------
   // drive value and enable follow the owner one clock later
   always_ff @(posedge clk) begin
      if (rst) begin
         pad_out <= 16'h0000;
         pad_oe <= 16'h0000;
      end else begin
         pad_out <= own_out_d;
         pad_oe <= own_oe_d;
      end
   end

   // pulls stay off while anyone drives the pin
   always_ff @(posedge clk) begin
      if (rst) begin
         pad_pull_en <= 16'h0000;
         pad_pull_dn <= 16'h0000;
      end else begin
         pad_pull_en <= pull_en_d;
         pad_pull_dn <= pull_dn_d;
      end
   end

   // slew control and input buffer are never on together
   always_ff @(posedge clk) begin
      if (rst) begin
         pad_slew_en <= 16'h0000;
         pad_ibuf_en <= 16'hffff;
      end else begin
         pad_slew_en <= slew_all;
         pad_ibuf_en <= ~slew_all;
      end
   end

   // ---------------------------------------------------------------
   // readback values
   // ---------------------------------------------------------------
   logic [15:0] pins_rd;
   logic [15:0] latch_rd;

   // buffer off reads one
   assign pins_rd = slew_all | pin_sync_q;
   // output: latch; input: one with slew else pin
   assign latch_rd = (dir_all & latch_all) | (~dir_all & pins_rd);

   logic [7:0] rd_d;

   always_comb begin
      case (paddr)
         MPC_OFF_U_LATCH: rd_d = latch_rd[7:0];
         MPC_OFF_U_PINS: rd_d = pins_rd[7:0];
         MPC_OFF_U_DIR: rd_d = cfg_u.dir;
         MPC_OFF_U_SLEW: rd_d = cfg_u.slew;
         MPC_OFF_U_PULLEN: rd_d = cfg_u.pullen;
         MPC_OFF_U_PULLPOL: rd_d = cfg_u.pullpol;
         MPC_OFF_V_LATCH: rd_d = latch_rd[15:8];
         MPC_OFF_V_PINS: rd_d = pins_rd[15:8];
         MPC_OFF_V_DIR: rd_d = cfg_v.dir;
         MPC_OFF_V_SLEW: rd_d = cfg_v.slew;
         MPC_OFF_V_PULLEN: rd_d = cfg_v.pullen;
         MPC_OFF_V_PULLPOL: rd_d = cfg_v.pullpol;
         default: rd_d = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // apb answer
   // ---------------------------------------------------------------
   // pready registered so outputs come from flops: one wait state per access
   always_ff @(posedge clk) begin
      if (rst) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= psel && penable && !pready_q;
      end
   end

   // read data is captured in the first access cycle and held until the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en && !pready_q) begin
         prdata <= {24'h00_0000, rd_d};
      end
   end

   // no error response exists: unmapped offsets simply read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= 1'b0;
      end
   end

   // pready pulses for one cycle per access
   assign pready = pready_q;

endmodule

`default_nettype wire

// >>> dv/mpc_motor_port_props.sv
// Purpose: pad ownership and apb timing checks
// Assumes: pad controls lag their causes by one clock
// Notes: bound to every instance of the port block
`timescale 1ns/1ps
`default_nettype none
module mpc_motor_port_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic [3:0] stall_detector_en,
   input wire logic [15:0] stall_detector_out,
   input wire logic [15:0] stall_detector_oe,
   input wire logic [7:0] motor_pwm_controller_en,
   input wire logic [15:0] motor_pwm_controller_out,
   input wire logic [15:0] pad_out,
   input wire logic [15:0] pad_oe,
   input wire logic [15:0] pad_pull_en,
   input wire logic [15:0] pad_slew_en,
   input wire logic [15:0] pad_ibuf_en
);
   default clocking cb @(posedge clk); endclocking
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   a_reset_hiz: assert property (rst |=>
      pad_oe == 16'h0 && pad_pull_en == 16'h0) else $error("pads not idle after reset");
   a_apb_wait: assert property (disable iff (rst) s_setup ##1 s_access |=> pready)
      else $error("apb answer late");
   a_pready_once: assert property (disable iff (rst) pready |=> !pready)
      else $error("pready longer than one cycle");
   a_slew_ibuf: assert property (disable iff (rst) pad_ibuf_en == ~pad_slew_en)
      else $error("input buffer not opposite slew");
   a_pull_output: assert property (disable iff (rst) (pad_pull_en & pad_oe) == 16'h0)
      else $error("pull active on driven pin");
   a_detector_v: assert property (disable iff (rst) stall_detector_en[3] |=>
      pad_out[15:12] == $past(stall_detector_out[15:12])
      && pad_oe[15:12] == $past(stall_detector_oe[15:12])) else $error("detector v wrong");
   a_detector_u: assert property (disable iff (rst) stall_detector_en[1] |=>
      pad_out[7:4] == $past(stall_detector_out[7:4])) else $error("detector u wrong");
   a_pwm_v: assert property (disable iff (rst)
      motor_pwm_controller_en[4] && !stall_detector_en[2]
      |=> pad_oe[9:8] == 2'b11 && pad_out[9:8] == $past(motor_pwm_controller_out[9:8]))
      else $error("pwm v wrong");
   a_pwm_u: assert property (disable iff (rst)
      motor_pwm_controller_en[1] && !stall_detector_en[0]
      |=> pad_oe[3:2] == 2'b11) else $error("pwm u not output");
endmodule
bind mpc_motor_port mpc_motor_port_props u_props (.*);
`default_nettype wire

// >>> dv/mpc_pin_model.sv
// Purpose: external pin circuitry seen by the pads
// Assumes: no outside driver on any pin
// Notes: a released pin without pull shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module mpc_pin_model (
   input wire logic clk,
   input wire logic [15:0] pad_out,
   input wire logic [15:0] pad_oe,
   input wire logic [15:0] pad_pull_en,
   input wire logic [15:0] pad_pull_dn,
   output logic [15:0] pad_in
);
   logic [15:0] last_q = 16'h0000;
   // only a driven or pulled pin has a level worth remembering
   always @(posedge clk) begin
      for (int i = 0; i < 16; i++) begin
         if (pad_oe[i] || pad_pull_en[i]) last_q[i] <= pad_in[i];
      end
   end
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else if (pad_pull_en[i]) pad_in[i] = ~pad_pull_dn[i];
         else pad_in[i] = ~last_q[i];
      end
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: register and pin ownership tests
// Assumes: apb answer timing as handed over
// Notes: expectations follow the pin model levels
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mpc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr;
   logic [3:0] sd_en = 4'h0;
   logic [7:0] pwm_en = 8'h00;
   logic [15:0] sd_out = 16'h9c3a, sd_oe = 16'h5af0, pwm_out = 16'h6e17;
   logic [15:0] pad_in, pad_out, pad_oe, pull_en, pull_dn, slew_en, ibuf_en;
   int failures = 0, cmp_count = 0;
   logic [11:0] cfg [10] = '{MPC_OFF_U_LATCH, MPC_OFF_U_DIR, MPC_OFF_U_SLEW,
      MPC_OFF_U_PULLEN, MPC_OFF_U_PULLPOL, MPC_OFF_V_LATCH, MPC_OFF_V_DIR,
      MPC_OFF_V_SLEW, MPC_OFF_V_PULLEN, MPC_OFF_V_PULLPOL};
   logic [7:0] wv [10] = '{8'h3c, 8'h0f, 8'h81, 8'hf0, 8'h55, 8'h51, 8'hf0, 8'h0c, 8'h33, 8'h11};
   always #2.5 clk = ~clk;
   mpc_motor_port dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .stall_detector_en(sd_en),
      .stall_detector_out(sd_out), .stall_detector_oe(sd_oe),
      .motor_pwm_controller_en(pwm_en), .motor_pwm_controller_out(pwm_out),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pull_en),
      .pad_pull_dn(pull_dn), .pad_slew_en(slew_en), .pad_ibuf_en(ibuf_en));
   mpc_pin_model pins (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pull_en(pull_en), .pad_pull_dn(pull_dn), .pad_in(pad_in));
   task stop_test;
      if (failures == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         stop_test();
      end
      r = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("oe", 32'(pad_oe), 32'h0);
      chk("pull", 32'(pull_en), 32'h0);
      foreach (cfg[i]) begin
         apb(1'b0, cfg[i], 32'h0, rd);
         chk("reset", rd, (i == 0 || i == 5) ? 32'hff : 32'h0);
         apb(1'b1, cfg[i], 32'(wv[i]), rd);
      end
      foreach (cfg[i]) begin
         apb(1'b0, cfg[i], 32'h0, rd);
         if (i != 0 && i != 5) chk("cfg", rd, 32'(wv[i]));
      end
      @(negedge clk);
      chk("oe", 32'(pad_oe), 32'hf00f);
      chk("out", 32'(pad_out & pad_oe), 32'h500c);
      chk("pull", 32'(pull_en), 32'h03f0);
      chk("pull dn", 32'(pull_dn), 32'h0150);
      chk("slew", 32'(slew_en), 32'h0c81);
      chk("ibuf", 32'(ibuf_en), 32'hf37e);
      apb(1'b0, MPC_OFF_V_LATCH, 32'h0, rd);
      chk("v latch", rd, 32'h5e);
      apb(1'b0, MPC_OFF_U_LATCH, 32'h0, rd);
      chk("u latch", rd, 32'hac);
      apb(1'b0, MPC_OFF_U_PINS, 32'h0, rd);
      chk("u pins", rd, 32'had);
      apb(1'b1, MPC_OFF_V_PINS, 32'hff, rd);
      apb(1'b0, MPC_OFF_V_PINS, 32'h0, rd);
      chk("v pins", rd, 32'h5e);
      apb(1'b0, 12'h040, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      chk("slverr", 32'(pslverr), 32'h0);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         sd_en <= 4'(1 << k);
         pwm_en <= 8'(3 << (2 * k));
         repeat (2) @(negedge clk);
         chk("sd out", 32'(pad_out[4*k+:4]), 32'(sd_out[4*k+:4]));
         chk("sd oe", 32'(pad_oe[4*k+:4]), 32'(sd_oe[4*k+:4]));
         @(posedge clk);
         sd_en <= 4'h0;
         repeat (2) @(negedge clk);
         chk("pwm out", 32'(pad_out[4*k+:4]), 32'(pwm_out[4*k+:4]));
         chk("pwm oe", 32'(pad_oe[4*k+:4]), 32'hf);
         @(posedge clk);
         pwm_en <= 8'h00;
      end
      repeat (2) @(negedge clk);
      chk("oe", 32'(pad_oe), 32'hf00f);
      apb(1'b1, MPC_OFF_U_DIR, 32'h0, rd);
      apb(1'b0, MPC_OFF_U_LATCH, 32'h0, rd);
      apb(1'b0, MPC_OFF_U_LATCH, 32'h0, rd);
      chk("u settled", rd, 32'ha3);
      stop_test();
   end
endmodule
`default_nettype wire
